// ==== pkg/led_fault_pkg.sv ====
package led_fault_pkg;
   // ==========================================================
   // Timing, in oscillator clock periods
   // ==========================================================
   // Disable time is a fixed ratio of the oscillator period
   localparam int unsigned DISABLE_TIME_PERIODS = 32768;
   // Default start-up fault blanking and open-fault time-out, in clocks
   localparam int unsigned FAULT_BLANK_PERIODS = 4096;
   localparam int unsigned OPEN_TIMEOUT_PERIODS = 1024;
   localparam int CNT_W = 16;

   // ==========================================================
   // Open-drain flag encoding (enable low = pin pulled down)
   // ==========================================================
   localparam logic FLAG_PULL_DOWN = 1'b0;
   localparam logic FLAG_RELEASE = 1'b1;

   // Open-fault sequencer states
   typedef enum logic [1:0] {
      OPEN_IDLE = 2'b00,
      OPEN_HOLD = 2'b01,
      OPEN_RETRY = 2'b10
   } open_state_t;
endpackage

// ==== src/sync2.sv ====
`timescale 1ns/100ps
module sync2 (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic d,
   output logic q
);
   logic meta_q;

   // ==========================================================
   // Two-stage synchroniser; first stage feeds only the second
   // ==========================================================
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ==== src/led_string_fault_manager.sv ====
`timescale 1ns/100ps
module led_string_fault_manager
   import led_fault_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = FAULT_BLANK_PERIODS,
   parameter int unsigned DISABLE_CYCLES = DISABLE_TIME_PERIODS,
   parameter int unsigned OPEN_CYCLES = OPEN_TIMEOUT_PERIODS
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic enable_in,
   input wire logic cmp_open,
   input wire logic cmp_ref_short,
   input wire logic cmp_nonref_short,
   input wire logic cmp_string_short,
   input wire logic cmp_node_short,
   input wire logic fault_flag_primary_in,
   input wire logic regulator_gate,
   output logic gate_drive_out,
   output logic fault_flag_primary_out,
   output logic fault_flag_primary_oe_n,
   output logic fault_flag_secondary_out,
   output logic fault_flag_secondary_oe_n,
   output logic led_short_status,
   output logic short_latched_status
);
   import led_fault_pkg::*;

   // ==========================================================
   // Input synchronisation
   // ==========================================================
   logic open_s, ref_s, nonref_s, str_s, node_s, pri_pin_s, en_s;

   // Each asynchronous input passes two flops before use; the
   // comparators move freely against our clock
   sync2 u_sync_open (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(cmp_open),
      .q(open_s)
   );
   sync2 u_sync_ref (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(cmp_ref_short),
      .q(ref_s)
   );
   sync2 u_sync_nonref (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(cmp_nonref_short),
      .q(nonref_s)
   );
   sync2 u_sync_str (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(cmp_string_short),
      .q(str_s)
   );
   sync2 u_sync_node (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(cmp_node_short),
      .q(node_s)
   );
   // Primary pin is read back so an outside sink can be seen
   sync2 u_sync_pri (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(fault_flag_primary_in),
      .q(pri_pin_s)
   );
   // Enable is a pin too, so it gets the same treatment
   sync2 u_sync_en (
      .clk_sys(clk_sys),
      .srst(srst),
      .d(enable_in),
      .q(en_s)
   );

   // ==========================================================
   // Start-up blanking
   // ==========================================================
   logic [CNT_W-1:0] blank_cnt_q, blank_cnt_d;
   logic blank_done_q, blank_done_d;
   wire blank_end = (blank_cnt_q == CNT_W'(BLANK_CYCLES - 1));

   // Blanking restarts whenever the converter is disabled
   always_comb begin
      blank_cnt_d = blank_cnt_q;
      blank_done_d = blank_done_q;
      if (!en_s) begin
         blank_cnt_d = '0;
         blank_done_d = 1'b0;
      end else if (!blank_done_q) begin
         blank_cnt_d = blank_cnt_q + CNT_W'(1);
         blank_done_d = blank_end;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         blank_cnt_q <= '0;
         blank_done_q <= 1'b0;
      end else begin
         blank_cnt_q <= blank_cnt_d;
         blank_done_q <= blank_done_d;
      end
   end

   // ==========================================================
   // Disable-time counter on enable low
   // ==========================================================
   logic [CNT_W:0] dis_cnt_q, dis_cnt_d;
   logic dis_expired_q, dis_expired_d;
   wire dis_end = (dis_cnt_q == (CNT_W+1)'(DISABLE_CYCLES - 1));

   // Width is one bit over, though the full 32768 count already fits in CNT_W bits
   always_comb begin
      dis_cnt_d = dis_cnt_q;
      dis_expired_d = dis_expired_q;
      if (en_s) begin
         dis_cnt_d = '0;
         dis_expired_d = 1'b0;
      end else if (!dis_expired_q) begin
         dis_cnt_d = dis_cnt_q + (CNT_W+1)'(1);
         dis_expired_d = dis_end;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dis_cnt_q <= '0;
         dis_expired_q <= 1'b0;
      end else begin
         dis_cnt_q <= dis_cnt_d;
         dis_expired_q <= dis_expired_d;
      end
   end

   // ==========================================================
   // Fault classification
   // ==========================================================
   // Open is ungated by blanking; the rest wait for blanking
   wire open_det = open_s;
   wire ref_short_det = ref_s & blank_done_q;
   wire nonref_short_det = nonref_s & blank_done_q;
   wire led_short_det = ref_short_det | nonref_short_det;
   wire string_short_det = (str_s | node_s) & blank_done_q;

   // ==========================================================
   // Latched string/output short
   // ==========================================================
   logic short_q, short_d;

   // Detection wins over the clear in the same cycle
   always_comb begin
      short_d = short_q;
      if (dis_expired_q)
         short_d = 1'b0;
      if (string_short_det)
         short_d = 1'b1;
   end

   always_ff @(posedge clk_sys) begin
      if (srst)
         short_q <= 1'b0;
      else
         short_q <= short_d;
   end

   // ==========================================================
   // Open-fault time-out sequencer
   // ==========================================================
   open_state_t open_st_q, open_st_d;
   logic [CNT_W-1:0] open_cnt_q, open_cnt_d;
   wire open_timeout = (open_cnt_q == CNT_W'(OPEN_CYCLES - 1));

   // After time-out drive resumes; a still-present open retriggers
   always_comb begin
      open_st_d = open_st_q;
      open_cnt_d = open_cnt_q;
      case (open_st_q)
         OPEN_IDLE: begin
            open_cnt_d = '0;
            if (open_det)
               open_st_d = OPEN_HOLD;
         end
         OPEN_HOLD: begin
            open_cnt_d = open_cnt_q + CNT_W'(1);
            if (open_timeout) begin
               open_st_d = OPEN_RETRY;
               open_cnt_d = '0;
            end
         end
         // One clock of drive with detection masked, so the retry
         // really switches before a lasting open trips it again
         OPEN_RETRY: begin
            open_cnt_d = '0;
            open_st_d = OPEN_IDLE;
         end
         default: begin
            open_st_d = OPEN_IDLE;
            open_cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         open_st_q <= OPEN_IDLE;
         open_cnt_q <= '0;
      end else begin
         open_st_q <= open_st_d;
         open_cnt_q <= open_cnt_d;
      end
   end

   // ==========================================================
   // Primary pin sense alignment
   // ==========================================================
   logic pri_rel_p1_q, pri_rel_p2_q;

   // Our own release needs two sync clocks to reach pri_pin_s; trusting
   // the pin sooner mistakes our pull-down for an outside override and
   // pulses the gate on as a short is entered
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pri_rel_p1_q <= 1'b0;
         pri_rel_p2_q <= 1'b0;
      end else begin
         pri_rel_p1_q <= (fault_flag_primary_oe_n == FLAG_RELEASE);
         pri_rel_p2_q <= pri_rel_p1_q;
      end
   end

   // ==========================================================
   // Output decode
   // ==========================================================
   wire open_idle = (open_st_q == OPEN_IDLE);
   wire open_hold = (open_st_q == OPEN_HOLD);
   // Open acts at once from idle; the retry clock masks it on purpose
   wire open_active = (open_det & open_idle) | open_hold;
   // Sensing a low pin while we release it means outside override
   wire pri_override = short_q & pri_rel_p2_q & ~pri_pin_s;
   wire short_block = (short_q | string_short_det) & ~pri_override;
   // LED shorts do not block switching
   wire drive_ok = en_s & regulator_gate & ~open_active & ~short_block;
   wire pri_release = short_q | string_short_det;
   wire sec_release = open_active | led_short_det;
   // Enable codes for the open-drain flags
   wire pri_oe_n_d = pri_release ? FLAG_RELEASE : FLAG_PULL_DOWN;
   wire sec_oe_n_d = sec_release ? FLAG_RELEASE : FLAG_PULL_DOWN;

   // Gate drive registered; open detection is one clock from sync
   always_ff @(posedge clk_sys) begin
      if (srst)
         gate_drive_out <= 1'b0;
      else
         gate_drive_out <= drive_ok;
   end

   // Flag enables registered so the pins never glitch on decode
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fault_flag_primary_oe_n <= FLAG_PULL_DOWN;
         fault_flag_secondary_oe_n <= FLAG_PULL_DOWN;
      end else begin
         fault_flag_primary_oe_n <= pri_oe_n_d;
         fault_flag_secondary_oe_n <= sec_oe_n_d;
      end
   end

   // Status copies; the latch shows its next value to save a clock
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         led_short_status <= 1'b0;
         short_latched_status <= 1'b0;
      end else begin
         led_short_status <= led_short_det;
         short_latched_status <= short_d;
      end
   end

   // Open-drain data is always low; only the enable moves
   always_ff @(posedge clk_sys) begin
      fault_flag_primary_out <= 1'b0;
      fault_flag_secondary_out <= 1'b0;
   end
endmodule

// ==== testbench/led_fault_assertions.sv ====
`timescale 1ns/100ps
module led_fault_checker #(
   parameter int unsigned BLANK_CYCLES = 16,
   parameter int unsigned DISABLE_CYCLES = 32,
   parameter int unsigned OPEN_CYCLES = 8
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic enable_in,
   input wire logic cmp_open,
   input wire logic fault_flag_primary_in,
   input wire logic regulator_gate,
   input wire logic gate_drive_out,
   input wire logic fault_flag_primary_oe_n,
   input wire logic fault_flag_secondary_oe_n,
   input wire logic led_short_status,
   input wire logic short_latched_status
);
   // ==========================================================
   // Enable run lengths; sync lag makes the design count later, never sooner
   localparam int RETRY_MAX = OPEN_CYCLES + 6;
   int low_run;
   int high_run;
   always_ff @(posedge clk_sys) begin
      low_run <= (srst || enable_in) ? 0 : low_run + 1;
      high_run <= (srst || !enable_in) ? 0 : high_run + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   open_gate_off_a: assert property ($rose(cmp_open) |-> ##[1:3] !gate_drive_out)
      else $error("gate still on after open");
   open_flag_rel_a: assert property ($rose(cmp_open) |-> ##[1:3] fault_flag_secondary_oe_n)
      else $error("secondary not released on open");
   open_retry_a: assert property ($fell(gate_drive_out) && cmp_open && enable_in &&
      regulator_gate && !short_latched_status |-> ##[1:RETRY_MAX] gate_drive_out)
      else $error("no retry after open time-out");
   short_sec_rel_a: assert property (led_short_status |-> fault_flag_secondary_oe_n)
      else $error("secondary held down during LED short");
   latch_gate_off_a: assert property (
      (short_latched_status && fault_flag_primary_in)[*4] |-> !gate_drive_out)
      else $error("gate on with latched short");
   override_on_a: assert property ((short_latched_status && !fault_flag_primary_in &&
      enable_in && regulator_gate && !cmp_open)[*4] |-> gate_drive_out && short_latched_status)
      else $error("override did not resume drive");
   latch_clear_a: assert property ($fell(short_latched_status) |-> low_run >= DISABLE_CYCLES)
      else $error("latch cleared early");
   clear_done_a: assert property (low_run == DISABLE_CYCLES + 6 |-> !short_latched_status)
      else $error("latch not cleared after disable time");
   blank_hold_a: assert property ($rose(short_latched_status) |-> high_run >= BLANK_CYCLES)
      else $error("short latched inside blanking");
endmodule
bind led_string_fault_manager led_fault_checker #(.BLANK_CYCLES(BLANK_CYCLES),
   .DISABLE_CYCLES(DISABLE_CYCLES), .OPEN_CYCLES(OPEN_CYCLES)) u_led_fault_checker (
   .clk_sys(clk_sys), .srst(srst), .enable_in(enable_in), .cmp_open(cmp_open),
   .fault_flag_primary_in(fault_flag_primary_in), .regulator_gate(regulator_gate),
   .gate_drive_out(gate_drive_out), .fault_flag_primary_oe_n(fault_flag_primary_oe_n),
   .fault_flag_secondary_oe_n(fault_flag_secondary_oe_n),
   .led_short_status(led_short_status), .short_latched_status(short_latched_status));

// ==== testbench/led_flag_pullups.sv ====
`timescale 1ns/100ps
module led_flag_pullups (
   input wire logic pri_out,
   input wire logic pri_oe_n,
   input wire logic sec_out,
   input wire logic sec_oe_n,
   input wire logic hold_pri_low,
   output logic pri_pin,
   output logic sec_pin
);
   // ==========================================================
   // Pull-ups show a released flag; an outside sink beats the primary pull-up
   assign pri_pin = hold_pri_low ? 1'b0 : (pri_oe_n ? 1'b1 : pri_out);
   assign sec_pin = sec_oe_n ? 1'b1 : sec_out;
endmodule

// ==== testbench/led_string_fault_manager_tb_top.sv ====
`timescale 1ns/100ps
module led_string_fault_manager_tb_top;
   // ==========================================================
   localparam int BL = 16, DS = 32, OC = 8;
   logic clk_sys = 0, srst = 1, enable_in = 1, regulator_gate = 1, hold_low = 0;
   logic cmp_open = 0, cmp_ref_short = 0, cmp_nonref_short = 0;
   logic cmp_string_short = 0, cmp_node_short = 0;
   logic gate_drive_out, pri_out, pri_oe_n, sec_out, sec_oe_n, pri_pin, sec_pin;
   logic led_short_status, short_latched_status, seen;
   int n_fail = 0, n_tests = 0, m_open = 0, m_lat = 0, m_ovr = 0, m_led = 0;
   logic [31:0] r;
   always #4 clk_sys = ~clk_sys;
   led_string_fault_manager #(.BLANK_CYCLES(BL), .DISABLE_CYCLES(DS), .OPEN_CYCLES(OC))
   u_led_string_fault_manager (.clk_sys(clk_sys), .srst(srst), .enable_in(enable_in),
      .cmp_open(cmp_open), .cmp_ref_short(cmp_ref_short), .cmp_nonref_short(cmp_nonref_short),
      .cmp_string_short(cmp_string_short), .cmp_node_short(cmp_node_short),
      .fault_flag_primary_in(pri_pin), .regulator_gate(regulator_gate),
      .gate_drive_out(gate_drive_out), .fault_flag_primary_out(pri_out),
      .fault_flag_primary_oe_n(pri_oe_n), .fault_flag_secondary_out(sec_out),
      .fault_flag_secondary_oe_n(sec_oe_n), .led_short_status(led_short_status),
      .short_latched_status(short_latched_status));
   led_flag_pullups u_led_flag_pullups (.pri_out(pri_out), .pri_oe_n(pri_oe_n),
      .sec_out(sec_out), .sec_oe_n(sec_oe_n), .hold_pri_low(hold_low),
      .pri_pin(pri_pin), .sec_pin(sec_pin));
   // Inputs move 1 ns after the edge so no race with the sampling flops
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string what, input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   // Reference model: open beats everything, override restores drive only
   task automatic check_model();
      chk("gate", gate_drive_out,
         m_open == 0 && (m_lat == 0 || m_ovr != 0) && regulator_gate == 1'b1);
      chk("secondary pin", sec_pin, m_open != 0 || m_led != 0);
      chk("primary pin", pri_pin, m_lat != 0 && m_ovr == 0);
      chk("latch", short_latched_status, m_lat != 0);
      chk("led short", led_short_status, m_led != 0);
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog, about ten times the expected run length
   initial begin
      repeat (3000) @(posedge clk_sys);
      n_fail++;
      close_out();
   end
   initial begin
      r = $urandom(39);
      cyc(6);
      srst = 0;
      cyc(2);
      cmp_open = 1; // Raised inside the start-up blanking window
      m_open = 1;
      cyc(4);
      check_model();
      seen = 0;
      repeat (OC + 12) begin
         cyc(1);
         seen = seen | gate_drive_out;
      end
      chk("retry", seen, 1'b1);
      cmp_open = 0;
      m_open = 0;
      cyc(OC + 8);
      check_model();
      $display("open test done");
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         cmp_ref_short = r[0];
         cmp_nonref_short = !r[0];
         regulator_gate = r[4]; // Random PWM demand must pass straight to the gate
         m_led = 1;
         cyc(4 + int'(r[3:1]));
         check_model();
         {cmp_ref_short, cmp_nonref_short} = 2'b00;
         m_led = 0;
         cyc(4);
         check_model();
      end
      regulator_gate = 1;
      $display("led short test done");
      for (int k = 0; k < 2; k++) begin
         cmp_string_short = (k == 0);
         cmp_node_short = (k == 1);
         m_lat = 1;
         cyc(4);
         {cmp_string_short, cmp_node_short} = 2'b00;
         cyc(4);
         check_model();
         hold_low = 1;
         m_ovr = 1;
         cyc(5);
         check_model();
         hold_low = 0;
         m_ovr = 0;
         enable_in = 0;
         cyc(DS / 2);
         enable_in = 1;
         cyc(5);
         check_model();
         enable_in = 0;
         cyc(DS + 8);
         enable_in = 1;
         m_lat = 0;
         cmp_string_short = 1; // Short pulse inside blanking is ignored
         cyc(4);
         cmp_string_short = 0;
         cyc(BL + 6);
         check_model();
         $display("string short pass %0d done", k);
      end
      close_out();
   end
endmodule
